/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "tpwm_regs.svh"
module tb_top;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 ext_pin = 1'b0; // external count clock
  logic                 cap_pin = 1'b0; // capture input
  tpwm_pkg::tpwm_bus_s  bus = '0;
  logic [31:0]          rdata;
  tpwm_pkg::tpwm_pins_s pins;
  logic [5:0]           gate;
  int                   fails = 0;
  int                   checks_done = 0;
  always #25 clk_sys = ~clk_sys;
  tpwm_timer uut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
    .ext_count_clock_pin(ext_pin), .capture_input_pin(cap_pin), .pins(pins));
  tpwm_stage_model stage (.clk_sys(clk_sys), .pins(pins), .gate(gate));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 32'h0, be: 4'hf, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ext_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  // reset value of every offset, one unmapped place at the end
  task automatic t_reset;
    logic [31:0] exp [16] = '{32'h0, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'h0,
      32'hfff, 32'h0, 32'h88, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 16; i++)
      rdchk(6'(i * 4), exp[i]);
  endtask
  // narrow lanes merge, reserved and read-only places ignore writes
  task automatic t_lanes;
    wr(`TPWM_OFS_PRD, 32'h0000_0034, 4'h1);
    wr(`TPWM_OFS_PRD, 32'h0000_1200, 4'h2);
    rdchk(`TPWM_OFS_PRD, 32'h1234);
    wr(`TPWM_OFS_CMPA, 32'hdead_beef, 4'hc);
    rdchk(`TPWM_OFS_CMPA, 32'hffff);
    wr(`TPWM_OFS_CMPB, 32'h0000_0000, 4'h3);
    rdchk(`TPWM_OFS_CMPB, 32'h0);
    wr(`TPWM_OFS_DIV, 32'h0000_5abc, 4'hf);
    rdchk(`TPWM_OFS_DIV, 32'habc);
    wr(`TPWM_OFS_PRD, 32'h0000_0002, 4'hf);
    rdchk(`TPWM_OFS_PRD, 32'h2);
    wr(`TPWM_OFS_CNT, 32'h1234, 4'hf);
    rdchk(`TPWM_OFS_CNT, 32'h0);
    wr(`TPWM_OFS_CAP, 32'h1234, 4'hf);
    rdchk(`TPWM_OFS_CAP, 32'h0);
  endtask
  // key gate on output control; disabled outputs show their idle level
  task automatic t_key;
    logic [31:0] d;
    wr(`TPWM_OFS_OUTC, 32'he06c_0055, 4'hf);
    wr(`TPWM_OFS_OUTC, 32'he06d_0022, 4'hf);
    wr(`TPWM_OFS_OUTC, 32'he06c_0022, 4'h3);
    rd(`TPWM_OFS_OUTC, d);
    check(d & 32'hffff, 32'hdd);
    check({26'h0, gate}, 32'h2d);
    wr(`TPWM_OFS_OUTC, 32'he06c_0022, 4'hf);
    repeat (3) @(posedge clk_sys);
    check({26'h0, gate}, 32'h12);
  endtask
  // external clock on either edge, clear and stop
  task automatic t_ext;
    wr(`TPWM_OFS_PRD, 32'hffff, 4'hf);
    for (int e = 0; e < 2; e++) begin
      wr(`TPWM_OFS_CTRL, 32'h4000 | (e << 11), 4'hf);
      wr(`TPWM_OFS_CTRL, 32'hc000 | (e << 11), 4'hf);
      pulses(5);
      rdchk(`TPWM_OFS_CNT, 32'h5);
      wr(`TPWM_OFS_CTRL, 32'hc001 | (e << 11), 4'hf);
      rdchk(`TPWM_OFS_CNT, 32'h0);
      rdchk(`TPWM_OFS_CTRL, 32'hc000 | (e << 11));
      pulses(1);
      wr(`TPWM_OFS_CTRL, 32'h4000 | (e << 11), 4'hf);
      pulses(2);
      rdchk(`TPWM_OFS_CNT, 32'h1);
    end
    wr(`TPWM_OFS_CTRL, 32'h0, 4'hf);
  endtask
  // internal tick every divider plus one clocks
  task automatic t_pre;
    logic [31:0] d;
    wr(`TPWM_OFS_DIV, 32'h3, 4'hf);
    wr(`TPWM_OFS_CTRL, 32'h8000, 4'hf);
    repeat (200) @(posedge clk_sys);
    rd(`TPWM_OFS_CNT, d);
    check({31'h0, d >= 47 && d <= 52}, 32'h1);
    wr(`TPWM_OFS_CTRL, 32'h0, 4'hf);
  endtask
  // each capture edge code: rise near count 12, fall near count 22
  task automatic t_cap;
    logic [31:0] d;
    int          lo;
    wr(`TPWM_OFS_DIV, 32'h0, 4'hf);
    for (int c = 0; c < 3; c++) begin
      wr(`TPWM_OFS_CTRL, 32'h0, 4'hf);
      wr(`TPWM_OFS_CTRL, 32'h9000 | (c << 6), 4'hf);
      repeat (10) @(posedge clk_sys);
      cap_pin <= 1'b1;
      repeat (10) @(posedge clk_sys);
      cap_pin <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd(`TPWM_OFS_CAP, d);
      lo = (c == 1) ? 8 : 18;
      check({31'h0, d >= lo && d <= lo + 8}, 32'h1);
    end
  endtask
  // period flag on every third match with the field at 2, period 3
  task automatic t_pmflag;
    logic [31:0] d;
    wr(`TPWM_OFS_CTRL, 32'h0, 4'hf);
    wr(`TPWM_OFS_PRD, 32'h3, 4'hf);
    wr(`TPWM_OFS_CTRL, 32'h8005, 4'hf);
    wr(`TPWM_OFS_IFLG, 32'h8, 4'h1);
    repeat (8) @(posedge clk_sys);
    rd(`TPWM_OFS_IFLG, d);
    check(d & 32'h8, 32'h0);
    rd(`TPWM_OFS_IFLG, d);
    check(d & 32'h8, 32'h8);
  endtask
  // six-channel and forced outputs, dead time on channel b, start level
  task automatic t_pwm;
    wr(`TPWM_OFS_OUTC, 32'he06c_3f00, 4'hf);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) check({26'h0, gate}, 32'h12);
    wr(`TPWM_OFS_CTRL, 32'h4, 4'hf);
    wr(`TPWM_OFS_DEAD, 32'h5, 4'hf);
    wr(`TPWM_OFS_CTRL, 32'h8204, 4'hf);
    repeat (7) @(posedge clk_sys);
    @(negedge clk_sys) check({26'h0, gate}, 32'h10);
    @(negedge clk_sys) check({26'h0, gate}, 32'h12);
    wr(`TPWM_OFS_CTRL, 32'h4, 4'hf);
    wr(`TPWM_OFS_CTRL, 32'h404, 4'hf);
    wr(`TPWM_OFS_CTRL, 32'h8404, 4'hf);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) check({26'h0, gate}, 32'h0);
    wr(`TPWM_OFS_OUTC, 32'he06c_7f00, 4'hf);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) check({26'h0, gate}, 32'h07);
  endtask
  initial begin
    #4_000_000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_lanes;
    t_key;
    t_ext;
    t_pre;
    t_cap;
    t_pmflag;
    t_pwm;
    report_and_stop;
  end
endmodule

/* bench/tpwm_stage_model.sv */
`timescale 1ns/1ps
// power stage gate sensing; a released gate line floats, so it is
// shown inverted from its last level rather than held
module tpwm_stage_model (
  input wire logic                 clk_sys,
  input wire tpwm_pkg::tpwm_pins_s pins,
  output logic [5:0]               gate
);
  logic [5:0] drive; // levels the timer puts out, b side on top
  logic [5:0] last;  // last level seen while driven
  assign drive = {pins.b_side, pins.a_side};
  assign gate = (drive & pins.oe) | (~last & ~pins.oe);
  // remember each driven level
  always_ff @(posedge clk_sys) begin
    last <= (drive & pins.oe) | (last & ~pins.oe);
  end
endmodule

/* bench/tpwm_timer_sva.sv */
`timescale 1ns/1ps
`include "tpwm_regs.svh"
// bus readback and pin enable checks, seen from the top ports only
module tpwm_timer_sva #(
  parameter int CNT_W  = 16,
  parameter int DIV_W  = 12,
  parameter int DEAD_W = 10
) (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire tpwm_pkg::tpwm_bus_s  bus,
  input wire logic [31:0]          rdata,
  input wire logic                 ext_count_clock_pin,
  input wire logic                 capture_input_pin,
  input wire tpwm_pkg::tpwm_pins_s pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] prd_sh;  // expected period readback
  logic [15:0] outc_sh; // expected output control, lower half
  // shadows merge byte lanes; a missing key drops the whole write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prd_sh  <= 16'hffff;
      outc_sh <= 16'h0000;
    end else if (ce && bus.wr) begin
      if (bus.addr == `TPWM_OFS_PRD) begin
        if (bus.be[0]) prd_sh[7:0] <= bus.wdata[7:0];
        if (bus.be[1]) prd_sh[15:8] <= bus.wdata[15:8];
      end
      if (bus.addr == `TPWM_OFS_OUTC && bus.be[3:2] == 2'b11 && bus.wdata[31:16] == `TPWM_KEY) begin
        if (bus.be[0]) outc_sh[7:0] <= bus.wdata[7:0];
        if (bus.be[1]) outc_sh[15:8] <= bus.wdata[15:8];
      end
    end
  end
  // a taken read of one offset
  sequence s_rd(logic [5:0] a);
    ce && bus.rd && bus.addr == a;
  endsequence
  property p_rd_idle; ce && !bus.rd |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero after idle");
  property p_prd; s_rd(`TPWM_OFS_PRD) |=> rdata == {16'h0000, prd_sh}; endproperty
  a_prd: assert property (p_prd) else $error("period readback wrong");
  property p_key; s_rd(`TPWM_OFS_OUTC) |=> rdata[15:0] == (outc_sh | 16'h0088); endproperty
  a_key: assert property (p_key) else $error("output control readback wrong");
  property p_clr; s_rd(`TPWM_OFS_CTRL) |=> !rdata[0] && rdata[31:16] == 16'h0; endproperty
  a_clr: assert property (p_clr) else $error("control clear bit reads set");
  property p_cnt; s_rd(`TPWM_OFS_CNT) |=> (rdata >> CNT_W) == 32'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("count wider than counter");
  property p_div; s_rd(`TPWM_OFS_DIV) |=> rdata[31:DIV_W] == '0; endproperty
  a_div: assert property (p_div) else $error("divider wider than field");
  property p_cap; s_rd(`TPWM_OFS_CAP) ##1 1'b1 |-> rdata[31:16] == 16'h0; endproperty
  a_cap: assert property (p_cap) else $error("capture value too wide");
  property p_cmp;
    s_rd(`TPWM_OFS_CMPA) or s_rd(`TPWM_OFS_CMPB) or s_rd(`TPWM_OFS_CMPC) |=> rdata[31:16] == 16'h0;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare upper half not zero");
  property p_oe; $fell(rst) |=> pins.oe == 6'h3f; endproperty
  a_oe: assert property (p_oe) else $error("outputs not driven after reset");
  c_key: cover property (s_rd(`TPWM_OFS_OUTC));
  c_cap: cover property (s_rd(`TPWM_OFS_CAP));
  c_pin: cover property ($rose(pins.a_side[0]));
endmodule
bind tpwm_timer tpwm_timer_sva #(.CNT_W(CNT_W), .DIV_W(DIV_W), .DEAD_W(DEAD_W)) chk (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
  .ext_count_clock_pin(ext_count_clock_pin), .capture_input_pin(capture_input_pin),
  .pins(pins)
);

/* pkg/tpwm_pkg.sv */
package tpwm_pkg;
  // one register bus request
  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        wr;
    logic        rd;
  } tpwm_bus_s;
  // pwm pin group, index 0..2 = channels a, b, c
  typedef struct packed {
    logic [2:0] a_side;
    logic [2:0] b_side;
    logic [5:0] oe;
  } tpwm_pins_s;
  // back-to-back count direction
  typedef enum logic {TPWM_UP, TPWM_DOWN} tpwm_dir_e;
endpackage

/* pkg/tpwm_regs.svh */
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH
// register byte offsets
`define TPWM_OFS_CTRL   6'h00
`define TPWM_OFS_PRD    6'h04
`define TPWM_OFS_CMPA   6'h08
`define TPWM_OFS_CMPB   6'h0c
`define TPWM_OFS_CMPC   6'h10
`define TPWM_OFS_CAP    6'h14
`define TPWM_OFS_DIV    6'h18
`define TPWM_OFS_CNT    6'h1c
`define TPWM_OFS_OUTC   6'h20
`define TPWM_OFS_DEAD   6'h24
`define TPWM_OFS_IEN    6'h28
`define TPWM_OFS_IFLG   6'h2c
`define TPWM_OFS_HIZ    6'h30
`define TPWM_OFS_ADTC   6'h34
`define TPWM_OFS_ADTD   6'h38
// control register fields
`define TPWM_RUN_BIT    15
`define TPWM_CLKSEL_BIT 14
`define TPWM_MODE_HI    13
`define TPWM_MODE_LO    12
`define TPWM_EDGE_BIT   11
`define TPWM_SINGLE_COMPARE_OUTPUT_MODE_BIT  10
`define TPWM_DTEN_BIT   9
`define TPWM_DTPOS_BIT  8
`define TPWM_CAPE_HI    7
`define TPWM_CAPE_LO    6
`define TPWM_RLD_HI     5
`define TPWM_RLD_LO     4
`define TPWM_PMD_HI     3
`define TPWM_PMD_LO     1
`define TPWM_CLR_BIT    0
// output control fields
`define TPWM_KEY        16'he06c
`define TPWM_B_SIDE_START_LEVEL_BIT   15
`define TPWM_A_SIDE_START_LEVEL_BIT   14
`define TPWM_OUTC_RSV1  32'h0000_0088
// high-impedance control fields
`define TPWM_HIZ_SW     4
`define TPWM_HIZ_STA    1
`define TPWM_HIZ_CLR    0
`define TPWM_HIZ_EN     7
`define TPWM_HIZ_RWMASK 32'h0000_0184
// reset values
`define TPWM_RST_CMP    16'hffff
`define TPWM_RST_DIV    12'hfff
// mode and option codes
`define TPWM_MODE_INT   2'h0
`define TPWM_MODE_CAP   2'h1
`define TPWM_MODE_B2B   2'h2
`define TPWM_CAP_FALL   2'h0
`define TPWM_CAP_RISE   2'h1
`define TPWM_CAP_BOTH   2'h2
`define TPWM_RLD_NOW    2'h0
`define TPWM_RLD_PM     2'h1
`define TPWM_RLD_BOT    2'h2
// flag positions
`define TPWM_FLG_HIZ    6
`define TPWM_FLG_CAP    5
`define TPWM_FLG_BOT    4
`define TPWM_FLG_PM     3
`define TPWM_FLG_A      2
`endif

/* rtl/tpwm_timer.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "tpwm_regs.svh"
// Notes on behaviour
// - registers take 32, 16, 8-bit accesses
// - run bit clears counter and starts
// - bit 14 picks prescaler or external clock
// - mode field: interval, capture, back-to-back
// - external edge bit picks falling or rising
// - force mode drives all from compare A
// - dead time enable delays A/B outputs
// - position bit swaps front/back delay
// - capture edge: falling, rising, both
// - reload timing: now, period, bottom
// - period flag every N+1 matches
// - clear bit zeroes decimation counter
// - clear bit resets counter, prescaler, self-clears
// - period range 2..ffff, never zero; the period register stores any written value, zero too
// - compare registers hold full 16 bits
// - capture register read-only, latched count
// - prescaler twelve bits, resets all ones
// - live count read-only, resets zero
// - output control needs key in top half
// - polarity bits set start level
// - disabled outputs drive their idle level
// - dead time is value plus one ticks
module tpwm_timer #(
  parameter int CNT_W  = 16, // counter width
  parameter int DIV_W  = 12, // prescaler width
  parameter int DEAD_W = 10  // dead time width
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire tpwm_pkg::tpwm_bus_s bus,
  output logic [31:0]             rdata,
  input  wire logic               ext_count_clock_pin,
  input  wire logic               capture_input_pin,
  output tpwm_pkg::tpwm_pins_s    pins
);

  // the register fields are laid out for these widths and no wider
  if (CNT_W < 2 || CNT_W > 16 || DIV_W < 1 || DIV_W > 12 || DEAD_W < 1 || DEAD_W > 10) begin
    $error("tpwm_timer: width parameter out of range");
  end

  // software-visible storage
  logic [15:0]       ctrl;        // control register, clear bit never stored
  logic [CNT_W-1:0]  prd;         // written period
  logic [CNT_W-1:0]  cmp [3];     // written compares a, b, c
  logic [CNT_W-1:0]  cap_val;     // captured count
  logic [DIV_W-1:0]  div;         // prescaler divide value
  logic [15:0]       outc;        // output control low half
  logic [DEAD_W-1:0] dead;        // dead time count
  logic [6:0]        ien;         // interrupt enable bits, stored only
  logic [6:0]        flg;         // sticky event flags
  logic [8:0]        hizc;        // high-impedance control
  logic [4:0]        adtc;        // converter trigger select, stored only
  logic [13:0]       adtd;        // converter trigger data, stored only

  // working state
  logic [CNT_W-1:0]  cnt;         // live count
  logic [CNT_W-1:0]  prd_w;       // working period buffer
  logic [CNT_W-1:0]  cmp_w [3];   // working compare buffers
  logic [DIV_W-1:0]  pre;         // prescaler count
  logic [2:0]        pmc;         // period-match decimation count
  tpwm_pkg::tpwm_dir_e dir;       // back-to-back direction
  logic              run_q;       // run bit one cycle ago
  logic [2:0]        ext_s;       // external clock sync, [2] is history
  logic [2:0]        cap_s;       // capture pin sync, [2] is history

  // decoded controls
  logic       run;
  logic [1:0] mode;
  logic       force_a;
  logic       wr_ctrl;
  logic       clr_req;
  logic       tick;
  logic       ext_edge;
  logic       cap_edge;
  logic       pm_ev;
  logic       bot_ev;
  logic [2:0] match_ev;
  logic [2:0] ev_set;

  assign run     = ctrl[`TPWM_RUN_BIT];
  assign mode    = ctrl[`TPWM_MODE_HI:`TPWM_MODE_LO];
  assign force_a = ctrl[`TPWM_SINGLE_COMPARE_OUTPUT_MODE_BIT];
  assign wr_ctrl = bus.wr && bus.addr == `TPWM_OFS_CTRL;
  // the self-clearing bit acts in the cycle of the write and is never held
  assign clr_req = wr_ctrl && bus.be[0] && bus.wdata[`TPWM_CLR_BIT];

  // byte-lane merge, so partial writes keep the other lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // external pins pass two flops; the third stage only keeps history for edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_s <= 3'h0;
      cap_s <= 3'h0;
    end else if (ce) begin
      ext_s <= {ext_s[1:0], ext_count_clock_pin};
      cap_s <= {cap_s[1:0], capture_input_pin};
    end
  end

  // selected external edge
  assign ext_edge = ctrl[`TPWM_EDGE_BIT] ? (ext_s[1] && !ext_s[2])
                                          : (!ext_s[1] && ext_s[2]);

  // selected capture edge; reserved code captures nothing
  always_comb begin
    unique case (ctrl[`TPWM_CAPE_HI:`TPWM_CAPE_LO])
      `TPWM_CAP_FALL: cap_edge = !cap_s[1] && cap_s[2];
      `TPWM_CAP_RISE: cap_edge = cap_s[1] && !cap_s[2];
      `TPWM_CAP_BOTH: cap_edge = cap_s[1] ^ cap_s[2];
      default:        cap_edge = 1'b0;
    endcase
  end

  // counting tick from prescaler or external pin
  assign tick = run && run_q && !clr_req &&
                (ctrl[`TPWM_CLKSEL_BIT] ? ext_edge : pre == div);

  // prescaler: wraps after div+1 system clocks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre <= '0;
    end else if (ce) begin
      if (clr_req || !run || !run_q) begin
        pre <= '0;
      end else if (pre == div) begin
        pre <= '0;
      end else begin
        pre <= pre + 1'b1;
      end
    end
  end

  // counter events
  assign pm_ev  = tick && cnt >= prd_w && !(mode == `TPWM_MODE_B2B && dir == tpwm_pkg::TPWM_DOWN);
  assign bot_ev = tick && (mode == `TPWM_MODE_B2B ? (dir == tpwm_pkg::TPWM_DOWN && cnt == '0)
                                                  : cnt >= prd_w);

  // counter and direction
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt   <= '0;
      dir   <= tpwm_pkg::TPWM_UP;
      run_q <= 1'b0;
    end else if (ce) begin
      run_q <= run;
      if (clr_req || (run && !run_q)) begin
        cnt <= '0;
        dir <= tpwm_pkg::TPWM_UP;
      end else if (tick) begin
        if (mode != `TPWM_MODE_B2B) begin
          cnt <= (cnt >= prd_w) ? '0 : cnt + 1'b1;
        end else if (dir == tpwm_pkg::TPWM_UP) begin
          if (cnt >= prd_w) begin
            dir <= tpwm_pkg::TPWM_DOWN;
            cnt <= cnt - 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end else if (cnt == '0) begin
          dir <= tpwm_pkg::TPWM_UP;
          cnt <= cnt + 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end

  // working buffers take written values at the chosen moment
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prd_w <= `TPWM_RST_CMP;
      cmp_w <= '{default: `TPWM_RST_CMP};
    end else if (ce) begin
      // a stopped timer always follows, so a fresh start uses fresh data
      if (!run || ctrl[`TPWM_RLD_HI:`TPWM_RLD_LO] == `TPWM_RLD_NOW ||
          (ctrl[`TPWM_RLD_HI:`TPWM_RLD_LO] == `TPWM_RLD_PM && pm_ev) ||
          (ctrl[`TPWM_RLD_HI:`TPWM_RLD_LO] == `TPWM_RLD_BOT && bot_ev)) begin
        prd_w <= prd;
        cmp_w <= cmp;
      end
    end
  end

  // decimation counter for the period-match flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pmc <= 3'h0;
    end else if (ce) begin
      if (clr_req) begin
        pmc <= 3'h0;
      end else if (pm_ev) begin
        pmc <= (pmc >= ctrl[`TPWM_PMD_HI:`TPWM_PMD_LO]) ? 3'h0 : pmc + 3'h1;
      end
    end
  end

  // capture latch, only in capture mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_val <= '0;
    end else if (ce && run && mode == `TPWM_MODE_CAP && cap_edge) begin
      cap_val <= cnt;
    end
  end

  // per-channel compare, dead time and pin drive
  logic [DEAD_W-1:0] dt_cnt [3];
  logic [2:0]        phase;
  logic [2:0]        phase_d;
  logic [2:0]        a_act;
  logic [2:0]        b_act;
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic [CNT_W-1:0] ref_v;
    assign ref_v       = force_a ? cmp_w[0] : cmp_w[c];
    assign phase[c]    = run && cnt >= ref_v;
    assign match_ev[c] = tick && cnt == ref_v;
    // delayed copy follows the phase dead+1 ticks later
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        phase_d[c] <= 1'b0;
        dt_cnt[c]  <= '0;
      end else if (ce) begin
        if (!ctrl[`TPWM_DTEN_BIT] || !run) begin
          phase_d[c] <= phase[c];
          dt_cnt[c]  <= '0;
        end else if (phase_d[c] == phase[c]) begin
          dt_cnt[c] <= '0;
        end else if (tick) begin
          if (dt_cnt[c] == dead) begin
            phase_d[c] <= phase[c];
            dt_cnt[c]  <= '0;
          end else begin
            dt_cnt[c] <= dt_cnt[c] + 1'b1;
          end
        end
      end
    end
    // front delay = late rise of active phase, back delay = late fall
    assign a_act[c] = ctrl[`TPWM_DTPOS_BIT] ? (phase[c] | phase_d[c])
                                            : (phase[c] & phase_d[c]);
    assign b_act[c] = ctrl[`TPWM_DTPOS_BIT] ? (phase[c] & phase_d[c])
                                            : (phase[c] | phase_d[c]);
    // enables a: bits 10..8, b: 13..11; idle levels a: 2..0, b: 6..4
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        pins.a_side[c] <= 1'b0;
        pins.b_side[c] <= 1'b0;
        pins.oe[c]     <= 1'b0;
        pins.oe[c+3]   <= 1'b0;
      end else if (ce) begin
        pins.a_side[c] <= outc[10-c] ? (outc[`TPWM_A_SIDE_START_LEVEL_BIT] ^ a_act[c])
                                     : outc[2-c];
        pins.b_side[c] <= outc[13-c] ? (outc[`TPWM_B_SIDE_START_LEVEL_BIT] ^ b_act[c])
                                     : outc[6-c];
        pins.oe[c]     <= !hizc[`TPWM_HIZ_STA];
        pins.oe[c+3]   <= !hizc[`TPWM_HIZ_STA];
      end
    end
  end

  // events that may raise a flag, gated by mode
  assign ev_set[2] = mode != `TPWM_MODE_CAP && match_ev[0];
  assign ev_set[1] = mode != `TPWM_MODE_CAP && match_ev[1];
  assign ev_set[0] = mode != `TPWM_MODE_CAP && match_ev[2];

  // register writes
  logic [31:0] wv;
  assign wv = bus.wdata;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= 16'h0;
      prd  <= `TPWM_RST_CMP;
      cmp  <= '{default: `TPWM_RST_CMP};
      div  <= `TPWM_RST_DIV;
      outc <= 16'h0;
      dead <= '0;
      ien  <= 7'h0;
      adtc <= 5'h0;
      adtd <= 14'h0;
    end else if (ce && bus.wr) begin
      unique case (bus.addr)
        `TPWM_OFS_CTRL: ctrl <= 16'(merge({16'h0, ctrl}, wv, bus.be)) & 16'hfffe;
        `TPWM_OFS_PRD:  prd  <= CNT_W'(merge({16'h0, 16'(prd)}, wv, bus.be));
        `TPWM_OFS_CMPA: cmp[0] <= CNT_W'(merge({16'h0, 16'(cmp[0])}, wv, bus.be));
        `TPWM_OFS_CMPB: cmp[1] <= CNT_W'(merge({16'h0, 16'(cmp[1])}, wv, bus.be));
        `TPWM_OFS_CMPC: cmp[2] <= CNT_W'(merge({16'h0, 16'(cmp[2])}, wv, bus.be));
        `TPWM_OFS_DIV:  div  <= DIV_W'(merge({20'h0, 12'(div)}, wv, bus.be));
        `TPWM_OFS_OUTC: begin
          // whole write dropped unless the key lands in both upper lanes
          if (bus.be[3:2] == 2'h3 && wv[31:16] == `TPWM_KEY) begin
            outc <= 16'(merge({16'h0, outc}, wv, bus.be)) & 16'hff77;
          end
        end
        `TPWM_OFS_DEAD: dead <= DEAD_W'(merge({22'h0, 10'(dead)}, wv, bus.be));
        `TPWM_OFS_IEN:  ien  <= 7'(merge({25'h0, ien}, wv, bus.be));
        `TPWM_OFS_ADTC: adtc <= 5'(merge({27'h0, adtc}, wv, bus.be));
        `TPWM_OFS_ADTD: adtd <= 14'(merge({18'h0, adtd}, wv, bus.be));
        default: ;
      endcase
    end
  end

  // high-impedance state: software set and clear, status read-only
  logic hiz_wr;
  logic hiz_set;
  logic [31:0] hiz_m;
  assign hiz_wr  = ce && bus.wr && bus.addr == `TPWM_OFS_HIZ;
  assign hiz_m   = merge(32'h0, wv, bus.be);
  assign hiz_set = hiz_wr && hiz_m[`TPWM_HIZ_SW] && hizc[`TPWM_HIZ_EN];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hizc <= 9'h0;
    end else if (ce) begin
      if (hiz_wr) begin
        hizc <= 9'(merge({23'h0, hizc}, wv, bus.be) & `TPWM_HIZ_RWMASK) |
                {7'h0, hizc[`TPWM_HIZ_STA], 1'b0};
      end
      // a set in the same write wins over a clear
      if (hiz_set) begin
        hizc[`TPWM_HIZ_STA] <= 1'b1;
      end else if (hiz_wr && hiz_m[`TPWM_HIZ_CLR]) begin
        hizc[`TPWM_HIZ_STA] <= 1'b0;
      end
    end
  end

  // sticky flags, write one to clear, a new event beats the clear
  logic [6:0] flg_new;
  logic [6:0] flg_clr;
  assign flg_new = {hiz_set,
                    ce && run && mode == `TPWM_MODE_CAP && cap_edge,
                    bot_ev && mode == `TPWM_MODE_B2B,
                    pm_ev && pmc >= ctrl[`TPWM_PMD_HI:`TPWM_PMD_LO],
                    ev_set};
  assign flg_clr = (bus.wr && bus.addr == `TPWM_OFS_IFLG) ?
                   7'(merge(32'h0, wv, bus.be)) : 7'h0;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flg <= 7'h0;
    end else if (ce) begin
      flg <= (flg & ~flg_clr) | flg_new;
    end
  end

  // read data stands in the cycle after the strobe only
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    unique case (bus.addr)
      `TPWM_OFS_CTRL: next_rdata = {16'h0, ctrl};
      `TPWM_OFS_PRD:  next_rdata = {16'h0, 16'(prd)};
      `TPWM_OFS_CMPA: next_rdata = {16'h0, 16'(cmp[0])};
      `TPWM_OFS_CMPB: next_rdata = {16'h0, 16'(cmp[1])};
      `TPWM_OFS_CMPC: next_rdata = {16'h0, 16'(cmp[2])};
      `TPWM_OFS_CAP:  next_rdata = {16'h0, 16'(cap_val)};
      `TPWM_OFS_DIV:  next_rdata = {20'h0, 12'(div)};
      `TPWM_OFS_CNT:  next_rdata = {16'h0, 16'(cnt)};
      `TPWM_OFS_OUTC: next_rdata = {16'h0, outc} | `TPWM_OUTC_RSV1;
      `TPWM_OFS_DEAD: next_rdata = {22'h0, 10'(dead)};
      `TPWM_OFS_IEN:  next_rdata = {25'h0, ien};
      `TPWM_OFS_IFLG: next_rdata = {25'h0, flg};
      `TPWM_OFS_HIZ:  next_rdata = {23'h0, hizc};
      `TPWM_OFS_ADTC: next_rdata = {27'h0, adtc};
      `TPWM_OFS_ADTD: next_rdata = {18'h0, adtd};
      default:        next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (ce) begin
      rdata <= bus.rd ? next_rdata : 32'h0;
    end
  end

endmodule
